// ==== scc_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the sense counter
// Assumes: included by the control module and the assertion checker
// Notes: definitions only
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
// ==========================================================
// register offsets (8-bit register port)
`define SCC_OFS_CTRL_A 8'hA0
`define SCC_OFS_CTRL_B 8'hA1
`define SCC_OFS_STATUS 8'hA8
`define SCC_OFS_MASK 8'hA9
`define SCC_OFS_CNT_LO 8'hAA
`define SCC_OFS_CNT_HI 8'hAB
// ==========================================================
// reset values
`define SCC_RST_CTRL_A 8'h00
`define SCC_RST_CTRL_B 8'h00
`define SCC_RST_IRQ 8'h00
// ==========================================================
// control register a fields
`define SCC_A_EN 0
`define SCC_A_MODE_LO 1
`define SCC_A_PRESCALE 3
`define SCC_A_CNT_SRC 4
`define SCC_A_SW_CLK 5
`define SCC_A_OUT_LO 6
// control register b fields
`define SCC_B_SEL_LO 0
`define SCC_B_INVERT 3
`define SCC_B_DIV_LO 5
`define SCC_B_CHAIN 7
// ==========================================================
// status bits
`define SCC_ST_STOP 0
`define SCC_ST_LO_WRAP 1
`define SCC_ST_HI_WRAP 2
// ==========================================================
// prescaled main clock divide ratio
`define SCC_PRESCALE_DIV 4
`endif

// ==== scc_pkg.sv ====
// Purpose: types shared by the sense counter control files
// Assumes: scc_defs.svh holds the numbers
// Notes: none
package scc_pkg;
    // ==========================================================
    // counting modes
    typedef enum logic [1:0] {
        SCC_MODE_EVENT = 2'h0,
        SCC_MODE_WIDTH = 2'h1,
        SCC_MODE_PERIOD = 2'h2,
        SCC_MODE_CONT = 2'h3
    } scc_mode_e;
    // counter run state
    typedef enum logic [1:0] {
        SCC_ST_IDLE = 2'h0,
        SCC_ST_ARM = 2'h1,
        SCC_ST_RUN = 2'h2,
        SCC_ST_DONE = 2'h3
    } scc_state_e;
    // external sources for the counter input
    typedef struct packed {
        logic comp0;
        logic low_osc;
        logic comp1;
        logic relax_tc;
        logic interval;
        logic relax_irq;
        logic mux_bus;
    } scc_src_s;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scc_req_s;
endpackage

// ==== scc_divider.sv ====
// Purpose: one-cycle enable pulses at clk/1, /2, /4, /8 of a source enable
// Assumes: src_en_in is one-cycle pulses on clk_in
// Notes: counts only while run_in is high; clears otherwise
module scc_divider #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic run_in,
    input wire logic src_en_in,
    input wire logic [1:0] sel_in,
    // pulse out
    output logic tick_out
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic [WIDTH-1:0] mask;

    // refuse a counter too narrow to divide by 8
    if (WIDTH < 3) begin : g_bad_width
        $error("scc_divider width too small");
    end

    // divide mask from select
    always_comb begin
        mask = WIDTH'((1 << sel_in) - 1);
        cnt_nxt = cnt_r;
        if (!run_in) begin
            cnt_nxt = '0;
        end else if (src_en_in) begin
            cnt_nxt = (cnt_r & mask) == mask ? '0 : cnt_r + 1'b1;
        end
    end

    assign tick_out = run_in && src_en_in && ((cnt_r & mask) == mask);

    // register count
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== scc_sense_counter_control.sv ====
// Purpose: control logic of a two-counter capacitive sensing counter block
// Assumes: clk_in is the internal main oscillator at 125 MHz; pins pass two flip-flops
// Notes: the prescaled main clock and divided clocks are one-cycle enables
// ==========================================================
// Overview of operation
// RULE1: software leaves control a bits 7 to 1 alone while enabled.
// RULE2: software never writes control b while enabled.
// RULE3: output select 00 input, 01 sensing irq, 10 low out, 11 high out.
// RULE4: switch clock bit picks prescaled clock (0) or random sequence (1).
// RULE5: counter source bit picks main clock (0) or prescaled clock (1).
// RULE6: prescaled mode moves timer one onto prescaled clock and lets counters toggle.
// RULE7: once prescaled mode is on, its divider runs freely and never restarts.
// RULE8: event mode counts from enable until an interrupt event.
// RULE9: pulse width mode counts from next rising to following falling input edge.
// RULE10: period mode counts from one rising input edge to the next.
// RULE11: continuous mode counts from enable until disable.
// RULE12: mode codes 00 event, 01 width, 10 period, 11 continuous.
// RULE13: clearing enable stops counting and zeroes all counters.
// RULE14: chain clear gives two 8-bit counters, set gives one 16-bit counter.
// RULE15: divider field gives main clock divided by 1, 2, 4 or 8; code divides the clock picked by the counter source bit.
// RULE16: invert bit passes the selected input straight or inverted.
// RULE17: input select picks one of eight sources, code 111 constant zero.
`include "scc_defs.svh"
module scc_sense_counter_control
    import scc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire scc_req_s req_in,
    output logic [7:0] rdata_out,
    // asynchronous sources and event
    input wire scc_src_s src_in,
    input wire logic prs_in,
    input wire logic stop_event_in,
    // timer one clock choices
    input wire logic timer_one_config_in,
    input wire logic slow_32k_tick_in,
    // outputs
    output logic pin_out,
    output logic switch_clk_out,
    output logic timer_one_tick_out,
    output logic [15:0] count_out,
    output logic irq_out
);
    // ==========================================================
    // synchronisers: sources, random sequence, stop event, slow tick
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] async_bits;
    assign async_bits = {slow_32k_tick_in, stop_event_in, prs_in, src_in};

    // two flip-flop stages
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= async_bits;
            sync2_r <= sync1_r;
        end
    end

    scc_src_s src_s;
    logic prs_s;
    logic stop_s;
    logic slow_s;
    logic slow_q_r;
    assign {slow_s, stop_s, prs_s, src_s} = sync2_r;

    // ==========================================================
    // registers
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_a_nxt;
    logic [7:0] ctrl_b_r;
    logic [7:0] ctrl_b_nxt;
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [2:0] mask_r;
    logic [2:0] mask_nxt;
    logic [7:0] rdata_nxt;
    logic [2:0] ev_set;

    logic enable;
    scc_mode_e mode;
    logic prescale_on;
    logic chain;
    assign enable = ctrl_a_r[`SCC_A_EN];
    assign mode = scc_mode_e'(ctrl_a_r[`SCC_A_MODE_LO +: 2]); // [RULE12]
    assign prescale_on = ctrl_a_r[`SCC_A_PRESCALE];
    assign chain = ctrl_b_r[`SCC_B_CHAIN];

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;

    // address match, used for write decode only; reads use a case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // register write and read next values
    always_comb begin
        ctrl_a_nxt = ctrl_a_r;
        ctrl_b_nxt = ctrl_b_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r | ev_set;
        rdata_nxt = 8'h00;
        if (req_in.wr) begin
            if (hit(req_in.addr, `SCC_OFS_CTRL_A)) begin
                ctrl_a_nxt = req_in.wdata;
            end
            if (hit(req_in.addr, `SCC_OFS_CTRL_B)) begin
                ctrl_b_nxt = req_in.wdata & 8'hEF;
            end
            if (hit(req_in.addr, `SCC_OFS_MASK)) begin
                mask_nxt = req_in.wdata[2:0];
            end
            if (hit(req_in.addr, `SCC_OFS_STATUS)) begin
                stat_nxt = (stat_r & ~req_in.wdata[2:0]) | ev_set; // set wins over clear
            end
        end
        if (req_in.rd) begin
            case (req_in.addr)
                `SCC_OFS_CTRL_A: rdata_nxt = ctrl_a_r;
                `SCC_OFS_CTRL_B: rdata_nxt = ctrl_b_r;
                `SCC_OFS_STATUS: rdata_nxt = {5'h00, stat_r};
                `SCC_OFS_MASK: rdata_nxt = {5'h00, mask_r};
                `SCC_OFS_CNT_LO: rdata_nxt = cnt_r[7:0];
                `SCC_OFS_CNT_HI: rdata_nxt = cnt_r[15:8];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_a_r <= `SCC_RST_CTRL_A;
            ctrl_b_r <= `SCC_RST_CTRL_B;
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            rdata_out <= 8'h00;
        end else begin
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_b_r <= ctrl_b_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_out <= rdata_nxt;
        end
    end

    // ==========================================================
    // prescaled main clock: free running once started
    logic [2:0] pre_cnt_r;
    logic [2:0] pre_cnt_nxt;
    logic pre_run_r;
    logic pre_run_nxt;
    logic pre_tick;
    assign pre_tick = pre_run_r && (pre_cnt_r == 3'(`SCC_PRESCALE_DIV - 1));

    // the three-bit prescale counter serves ratios 2 to 8 only
    if (`SCC_PRESCALE_DIV < 2 || `SCC_PRESCALE_DIV > 8) begin : g_bad_prescale
        $error("prescale ratio out of range");
    end

    // divider next state
    always_comb begin
        pre_run_nxt = pre_run_r | prescale_on; // [RULE7]
        pre_cnt_nxt = pre_cnt_r;
        if (pre_run_r) begin
            pre_cnt_nxt = pre_tick ? 3'h0 : pre_cnt_r + 3'h1; // [RULE7]
        end
    end

    // divider storage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pre_run_r <= 1'b0;
            pre_cnt_r <= 3'h0;
        end else begin
            pre_run_r <= pre_run_nxt;
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // ==========================================================
    // counter clock: source then divide
    logic src_tick;
    logic cnt_tick;
    assign src_tick = ctrl_a_r[`SCC_A_CNT_SRC] ? pre_tick : 1'b1; // [RULE5]

    scc_divider #(
        .WIDTH(3)
    ) u_div (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(enable),
        .src_en_in(src_tick),
        .sel_in(ctrl_b_r[`SCC_B_DIV_LO +: 2]), // [RULE15]
        .tick_out(cnt_tick)
    );

    // ==========================================================
    // input selection and inversion
    logic in_raw;
    logic in_sel;
    logic in_q_r;
    always_comb begin
        case (ctrl_b_r[`SCC_B_SEL_LO +: 3]) // [RULE17]
            3'h0: in_raw = src_s.comp0;
            3'h1: in_raw = src_s.low_osc;
            3'h2: in_raw = src_s.comp1;
            3'h3: in_raw = src_s.relax_tc;
            3'h4: in_raw = src_s.interval;
            3'h5: in_raw = src_s.relax_irq;
            3'h6: in_raw = src_s.mux_bus;
            default: in_raw = 1'b0;
        endcase
        in_sel = in_raw ^ ctrl_b_r[`SCC_B_INVERT]; // [RULE16]
    end

    logic rise;
    logic fall;
    assign rise = in_sel && !in_q_r;
    assign fall = !in_sel && in_q_r;

    // ==========================================================
    // counting state machine and counters
    scc_state_e st_r;
    scc_state_e st_nxt;
    logic counting;
    logic lo_wrap;
    logic hi_wrap;
    logic stop_now;

    // next state and counter values
    always_comb begin
        st_nxt = st_r;
        stop_now = 1'b0;
        case (st_r)
            SCC_ST_IDLE: begin
                if (enable) begin
                    st_nxt = (mode == SCC_MODE_EVENT || mode == SCC_MODE_CONT) ?
                        SCC_ST_RUN : SCC_ST_ARM; // [RULE8] [RULE11]
                end
            end
            SCC_ST_ARM: begin
                if (rise) begin
                    st_nxt = SCC_ST_RUN; // [RULE9] [RULE10]
                end
            end
            SCC_ST_RUN: begin
                case (mode)
                    SCC_MODE_EVENT: stop_now = stop_s; // [RULE8]
                    SCC_MODE_WIDTH: stop_now = fall; // [RULE9]
                    SCC_MODE_PERIOD: stop_now = rise; // [RULE10]
                    default: stop_now = 1'b0; // [RULE11]
                endcase
                if (stop_now) begin
                    st_nxt = SCC_ST_DONE;
                end
            end
            default: st_nxt = SCC_ST_DONE;
        endcase
        if (!enable) begin
            st_nxt = SCC_ST_IDLE; // [RULE13]
        end
        counting = (st_r == SCC_ST_RUN) && !stop_now && cnt_tick && prescale_on; // [RULE6]
        lo_wrap = counting && (cnt_r[7:0] == 8'hFF);
        hi_wrap = 1'b0;
        cnt_nxt = cnt_r;
        if (counting) begin
            if (chain) begin
                cnt_nxt = cnt_r + 16'h0001; // [RULE14]
                hi_wrap = (cnt_r == 16'hFFFF);
            end else begin
                cnt_nxt[7:0] = cnt_r[7:0] + 8'h01; // [RULE14]
                cnt_nxt[15:8] = cnt_r[15:8] + 8'h01;
                hi_wrap = (cnt_r[15:8] == 8'hFF);
            end
        end
        if (!enable) begin
            cnt_nxt = 16'h0000; // [RULE13]
        end
        ev_set = {hi_wrap, lo_wrap, stop_now && enable};
    end

    // state storage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= SCC_ST_IDLE;
            cnt_r <= 16'h0000;
            in_q_r <= 1'b0;
            slow_q_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            in_q_r <= in_sel;
            slow_q_r <= slow_s;
        end
    end

    // ==========================================================
    // output selection and registered outputs
    logic irq_nxt;
    logic pin_nxt;
    logic t1_nxt;
    always_comb begin
        irq_nxt = |(stat_nxt & mask_nxt);
        case (ctrl_a_r[`SCC_A_OUT_LO +: 2]) // [RULE3]
            2'h0: pin_nxt = in_sel;
            2'h1: pin_nxt = irq_out;
            2'h2: pin_nxt = lo_wrap;
            default: pin_nxt = hi_wrap;
        endcase
        if (prescale_on) begin
            t1_nxt = pre_tick; // [RULE6]
        end else begin
            t1_nxt = timer_one_config_in ? (slow_s && !slow_q_r) : 1'b1; // [RULE6]
        end
    end

    // output flops
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
            pin_out <= 1'b0;
            switch_clk_out <= 1'b0;
            timer_one_tick_out <= 1'b0;
            count_out <= 16'h0000;
        end else begin
            irq_out <= irq_nxt;
            pin_out <= pin_nxt;
            switch_clk_out <= ctrl_a_r[`SCC_A_SW_CLK] ? prs_s : pre_tick; // [RULE4]
            timer_one_tick_out <= t1_nxt;
            count_out <= cnt_nxt;
        end
    end
endmodule

// ==== scc_src_model.sv ====
// Purpose: far-side sources that feed the sense counter input
// Assumes: steps on the bench clock
// Notes: comp0 becomes a square wave while high_in is nonzero
module scc_src_model
    import scc_pkg::*;
(
    // clock and settings
    input wire logic clk_in,
    input wire logic [6:0] level_in,
    input wire logic [7:0] high_in,
    input wire logic [7:0] low_in,
    // source levels
    output scc_src_s src_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] n_r = 8'h00;
    logic w_r = 1'b0;
    // phase counter of the comparator wave
    always @(posedge clk_in) begin
        if (n_r + 8'h01 >= (w_r ? high_in : low_in)) begin
            n_r <= 8'h00;
            w_r <= !w_r;
        end else begin
            n_r <= n_r + 8'h01;
        end
    end
    // fixed levels, comparator 0 replaced by the wave
    always_comb begin
        src_out = level_in;
        if (high_in != 8'h00) begin
            src_out.comp0 = w_r;
        end
    end
endmodule

// ==== scc_sense_counter_control_asserts.sv ====
// Purpose: port checker for the sense counter control block
// Assumes: one clock, synchronous active-high reset
// Notes: control registers are shadowed from port writes
`include "scc_defs.svh"
module scc_sense_counter_control_asserts
    import scc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // watched ports
    input wire scc_req_s req_in,
    input wire logic prs_in,
    input wire logic stop_event_in,
    input wire logic [7:0] rdata_out,
    input wire logic switch_clk_out,
    input wire logic timer_one_tick_out,
    input wire logic [15:0] count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // shadow state
    logic [7:0] a_r, a_nxt, b_r, b_nxt, q_r, q_nxt, e_r, e_nxt;
    logic cont;
    // next shadows, cycles since a control write, cycles of event high
    always_comb begin
        a_nxt = a_r;
        b_nxt = b_r;
        q_nxt = (q_r == 8'hFF) ? q_r : q_r + 8'h01;
        e_nxt = !stop_event_in ? 8'h00 : (e_r == 8'hFF) ? e_r : e_r + 8'h01;
        if (req_in.wr && req_in.addr == `SCC_OFS_CTRL_A) begin
            a_nxt = req_in.wdata;
            q_nxt = 8'h00;
        end
        if (req_in.wr && req_in.addr == `SCC_OFS_CTRL_B) begin
            b_nxt = req_in.wdata;
            q_nxt = 8'h00;
        end
    end
    // register the shadows
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            a_r <= `SCC_RST_CTRL_A;
            b_r <= `SCC_RST_CTRL_B;
            q_r <= 8'h00;
            e_r <= 8'h00;
        end else begin
            a_r <= a_nxt;
            b_r <= b_nxt;
            q_r <= q_nxt;
            e_r <= e_nxt;
        end
    end
    // settled continuous counting
    assign cont = a_r[0] && a_r[3] && a_r[2:1] == 2'h3 && q_r > 8'h08 && !req_in.wr;
    // ====
    // assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    AST_READ_A: assert property (
        req_in.rd && req_in.addr == `SCC_OFS_CTRL_A |=> rdata_out == a_r)
        else $error("control a read-back differs");
    AST_OFF_ZERO: assert property (
        !a_r[0] && q_r > 8'h02 |-> count_out == 16'h0000)
        else $error("count not zero while disabled");
    AST_CONT_STEP: assert property (
        cont && b_r[6:5] == 2'h0 && !a_r[4] |=> count_out == (b_r[7] ?
        $past(count_out) + 16'h0001 :
        {$past(count_out[15:8]) + 8'h01, $past(count_out[7:0]) + 8'h01}))
        else $error("continuous step wrong");
    AST_DIV8: assert property (disable iff (sys_rst_in || q_r == 8'h00)
        cont && b_r[6:5] == 2'h3 && !a_r[4] && $changed(count_out)
        |=> $stable(count_out) [*7] ##1 $changed(count_out))
        else $error("divide by 8 spacing wrong");
    AST_SRC_PRE: assert property (disable iff (sys_rst_in || q_r == 8'h00)
        cont && b_r[6:5] == 2'h0 && a_r[4] && $changed(count_out)
        |=> $stable(count_out) [*3] ##1 $changed(count_out))
        else $error("prescaled source spacing wrong");
    AST_PRE_TICK: assert property (disable iff (sys_rst_in || q_r == 8'h00)
        a_r[3] && q_r > 8'h08 && timer_one_tick_out
        |=> !timer_one_tick_out [*3] ##1 timer_one_tick_out)
        else $error("timer tick not every fourth cycle");
    AST_SW_PRS: assert property (
        (a_r[5] && $stable(prs_in)) [*6] |-> switch_clk_out == prs_in)
        else $error("switch clock does not follow sequence");
    AST_EVENT_HOLD: assert property (
        a_r[0] && a_r[2:1] == 2'h0 && e_r > 8'h05 |-> $stable(count_out))
        else $error("event mode still counting");
    COV_WIDTH: cover property (a_r[0] && a_r[2:1] == 2'h1);
    COV_EVENT: cover property (a_r[0] && e_r > 8'h05);
    COV_CHAIN: cover property (b_r[7] && count_out == 16'h0100);
endmodule
bind scc_sense_counter_control scc_sense_counter_control_asserts u_asserts (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(req_in),
    .prs_in(prs_in),
    .stop_event_in(stop_event_in),
    .rdata_out(rdata_out),
    .switch_clk_out(switch_clk_out),
    .timer_one_tick_out(timer_one_tick_out),
    .count_out(count_out)
);

// ==== tb_sense_counter_control.sv ====
// Purpose: self-checking bench for the sense counter control block
// Assumes: scc_src_model drives the counter sources
// Notes: registers are reached through the acc task
module tb_sense_counter_control
    import scc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // stimulus and observed signals
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    scc_req_s req_in = '0;
    logic prs_in = 1'b0;
    logic stop_event_in = 1'b0;
    logic timer_one_config_in = 1'b0;
    logic slow_32k_tick_in = 1'b0;
    logic [3:0] sc = 4'h0;
    logic [6:0] level = 7'h00;
    logic [7:0] hi_len = 8'h00;
    scc_src_s src;
    logic [7:0] rdata_out, rd_v;
    logic pin_out, switch_clk_out, timer_one_tick_out, irq_out;
    logic [15:0] count_out, c0, c1;
    logic [15:0] m [3];
    int errors = 0;
    int tests_run = 0;
    int k, w;
    // bench clock and a slow clock with a 16-cycle period
    always #4 clk_in = !clk_in;
    always @(posedge clk_in) begin
        sc <= sc + 4'h1;
        slow_32k_tick_in <= sc[3];
    end
    // sources and the block
    scc_src_model src_m (
        .clk_in(clk_in),
        .level_in(level),
        .high_in(hi_len),
        .low_in(8'h0E),
        .src_out(src)
    );
    scc_sense_counter_control dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .req_in(req_in),
        .rdata_out(rdata_out),
        .src_in(src),
        .prs_in(prs_in),
        .stop_event_in(stop_event_in),
        .timer_one_config_in(timer_one_config_in),
        .slow_32k_tick_in(slow_32k_tick_in),
        .pin_out(pin_out),
        .switch_clk_out(switch_clk_out),
        .timer_one_tick_out(timer_one_tick_out),
        .count_out(count_out),
        .irq_out(irq_out)
    );
    // ====
    // tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one write (w1=1) or read; read data taken the cycle after
    task automatic acc(input logic w1, input logic [7:0] a, input logic [7:0] d);
        req_in <= '{addr: a, wdata: d, wr: w1, rd: !w1};
        @(posedge clk_in);
        req_in <= '0;
        @(posedge clk_in);
        rd_v = rdata_out;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // count high cycles of pin, switch clock or timer tick
    task automatic ones(input int n, input int s);
        w = 0;
        repeat (n) begin
            @(posedge clk_in);
            w += (s == 0) ? pin_out : (s == 1) ? switch_clk_out : timer_one_tick_out;
        end
    endtask
    function automatic logic exp_in(input logic [6:0] lv, input logic [2:0] s);
        return (s == 3'h7) ? 1'b0 : lv[3'h6 - s];
    endfunction
    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog far beyond the expected run of under two thousand cycles
    initial begin
        cyc(20000);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end
    // ====
    // main sequence; control b written only while disabled
    initial begin
        cyc(4);
        sys_rst_in <= 1'b0;
        cyc(1);
        for (k = 0; k < 2; k++) begin
            acc(0, 8'hA0 + k[7:0], 8'h00);
            check(rd_v, 8'h00);
        end
        acc(1, 8'hA1, 8'hFF);
        acc(0, 8'hA1, 8'h00);
        check(rd_v, 8'hEF);
        acc(1, 8'hA5, 8'h5A);
        acc(0, 8'hA5, 8'h00);
        check(rd_v, 8'h00);
        for (k = 0; k < 32; k++) begin
            level <= k[4] ? 7'h35 : 7'h4A;
            acc(1, 8'hA1, {4'h0, k[3], k[2:0]});
            cyc(6);
            check(pin_out, exp_in(k[4] ? 7'h35 : 7'h4A, k[2:0]) ^ k[3]);
        end
        acc(1, 8'hA1, 8'h00);
        acc(1, 8'hA0, 8'h0F);
        cyc(20);
        check(count_out[15:8], count_out[7:0]);
        acc(1, 8'hA0, 8'h0E);
        cyc(2);
        check(count_out, 16'h0000);
        // wrap pulses on the pin: chained low, unchained high
        for (k = 0; k < 2; k++) begin
            acc(1, 8'hA1, k ? 8'h00 : 8'h80);
            acc(1, 8'hA0, k ? 8'hCF : 8'h8F);
            ones(300, 0);
            check(w[15:0], 16'h0001);
            if (k == 0) check(count_out[15:8], 8'h01);
            acc(1, 8'hA0, k ? 8'hCE : 8'h8E);
        end
        for (k = 0; k < 8; k++) begin
            acc(1, 8'hA1, {1'b0, k[1:0], 5'h00});
            acc(1, 8'hA0, {3'h0, k[2], 4'hF});
            cyc(10);
            c0 = count_out;
            cyc(32);
            c1 = count_out - c0;
            check(c1[7:0], 8'h20 >> ({1'b0, k[1:0]} + {k[2], 1'b0}));
            acc(1, 8'hA0, {3'h0, k[2], 4'hE});
        end
        hi_len <= 8'h06;
        for (k = 0; k < 3; k++) begin
            acc(1, 8'hA1, k == 2 ? 8'h88 : 8'h80);
            acc(1, 8'hA0, k == 1 ? 8'h0D : 8'h0B);
            cyc(60);
            m[k] = count_out;
            cyc(30);
            check(count_out, m[k]);
            acc(1, 8'hA0, k == 1 ? 8'h0C : 8'h0A);
        end
        check(m[1] - m[0], 16'h000E);
        check(m[1] - m[2], 16'h0006);
        hi_len <= 8'h00;
        acc(1, 8'hA8, 8'hFF);
        acc(1, 8'hA9, 8'h01);
        acc(1, 8'hA0, 8'h49);
        cyc(10);
        stop_event_in <= 1'b1;
        cyc(8);
        c0 = count_out;
        stop_event_in <= 1'b0;
        cyc(8);
        check(count_out, c0);
        check(pin_out, 1'b1);
        acc(0, 8'hA8, 8'h00);
        check(rd_v, 8'h01);
        acc(1, 8'hA9, 8'h00);
        check(irq_out, 1'b0);
        acc(1, 8'hA9, 8'h01);
        check(irq_out, 1'b1);
        acc(1, 8'hA8, 8'h01);
        acc(0, 8'hA8, 8'h00);
        check(rd_v, 8'h00);
        check(irq_out, 1'b0);
        acc(1, 8'hA0, 8'h48); // clear enable alone first
        acc(1, 8'hA0, 8'h08);
        ones(16, 1);
        check(w[15:0], 16'h0004);
        ones(16, 2);
        check(w[15:0], 16'h0004);
        acc(1, 8'hA0, 8'h28);
        prs_in <= 1'b1;
        cyc(6);
        check(switch_clk_out, 1'b1);
        prs_in <= 1'b0;
        cyc(6);
        check(switch_clk_out, 1'b0);
        acc(1, 8'hA0, 8'h00);
        ones(16, 2);
        check(w[15:0], 16'h0010);
        timer_one_config_in <= 1'b1;
        cyc(2);
        ones(64, 2);
        check(w[15:0], 16'h0004);
        end_of_test();
    end
endmodule
